/* vfpm_monitor.sv */
// Function
// - Sample monitor pin every 132us into register
// - At 900mV reading is FFh, alert low
// - Monitor pin above 1.12V causes shutdown
// - Ready low in shutdown, high after soft-start
// - Ready low on fault, disable, off-code
// - Config 01h keeps ready high on 00h
// - Aux ready behaves like main, independently, except that overcurrent never drops it
// - Overvoltage active from reset, fixed 2.3V first
// - Track reference plus 179mV after soft-start
// - Overvoltage drives low, tri-states below release
// - Overvoltage latches until reset or re-enable
// - Peak overcurrent forces phase low this cycle
// - Average overcurrent above 100uA causes shutdown
// - Overcurrent: tri-state, wait 8ms, retry
// - Overtemp output released before enable
// - Assert below on-level, release above off-level
// - Levels chosen by max temperature setting
// - Wait 4.6ms start-up delay before ramp
`timescale 1ns/1ps
`default_nettype none
`include "vfpm_map.svh"

module vfpm_monitor
  import vfpm_pkg::*;
#(
  parameter int          SAMPLE_CYC = `VFPM_SAMPLE_CYC,
  parameter int          TD1_CYC    = `VFPM_TD1_CYC,
  parameter int          HICCUP_CYC = `VFPM_HICCUP_CYC,
  parameter logic [7:0]  MAIN_CFG   = `VFPM_CFG_MAIN_RST,
  parameter logic [7:0]  AUX_CFG    = `VFPM_CFG_AUX_RST
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Analog comparators, converters and enables
  input  wire vfpm_sense_t sensors,
  // Modulator cycle starts and temperature setting
  input  wire logic [4:0]  cycleStart,
  input  wire logic [2:0]  maxTempSetting,
  // Register read port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regRead,
  output logic [7:0]       regData,
  output logic             regValid,
  // PWM commands, phase 4 is the aux rail
  output vfpm_pwm_t [4:0]  pwmCmd,
  // Open-drain pins
  output vfpm_od_t         mainRailReady,
  output vfpm_od_t         auxRailReady,
  output vfpm_od_t         regulatorOvertempN,
  output vfpm_od_t         alertN
);

  localparam int CW = 20;
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  vfpm_sense_t senseMeta;
  vfpm_sense_t sense;
  logic        enabled;
  logic        enPrev;
  logic        enRise;

  // two-flop sync, enable history kept alongside
  // Multi-bit codes may tear for one cycle; the next sample fixes it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      senseMeta <= '0;
      sense     <= '0;
      enPrev    <= 1'b0;
    end else begin
      senseMeta <= sensors;
      sense     <= senseMeta;
      enPrev    <= enabled;
    end
  end

  // Both enables must be high; a rising edge reopens a latched rail
  assign enabled = sense.powerEnableIn & sense.terminationEnableIn;
  assign enRise  = enabled & ~enPrev;

  ////////////////////////////////////////////////////////////////////////
  // Output current reading
  logic [CW-1:0] sampleCnt;
  logic          sampleTick;
  logic [7:0]    reading;
  logic          alertOn;
  assign sampleTick = (sampleCnt == CW'(SAMPLE_CYC - 1));
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sampleCnt <= '0;
    end else if (sampleTick) begin
      sampleCnt <= '0;
    end else begin
      sampleCnt <= sampleCnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reading <= '0;
      alertOn <= 1'b0;
    end else if (sampleTick) begin
      reading <= sense.imonFull ? `VFPM_OUTPUT_CURRENT_READING_FULL : sense.imonCode;
      alertOn <= sense.imonFull;
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regData  <= '0;
      regValid <= 1'b0;
    end else begin
      regValid <= regRead;
      regData  <= (regRead && regAddr == `VFPM_ADDR_OUTPUT_CURRENT_READING) ? reading : '0;
    end
  end

  assign alertN = '{out: 1'b0, oe: alertOn};
  a_output_current_reading_full: assert property (@(posedge core_clk) disable iff (reset)
    sampleTick && sense.imonFull |=> reading == `VFPM_OUTPUT_CURRENT_READING_FULL)
    else $error("reading not saturated");
  a_output_current_reading_sample: assert property (@(posedge core_clk) disable iff (reset)
    sampleTick && !sense.imonFull |=> reading == $past(sense.imonCode))
    else $error("reading not sampled");

  ////////////////////////////////////////////////////////////////////////
  // Rail sequencing and protection
  vfpm_rail_st_t railSt [2];
  logic [1:0]    ovLow;
  logic [1:0]    readyQ;

  for (genvar r = 0; r < 2; r++) begin : g_rail
    localparam logic [7:0] CFG = (r == 0) ? MAIN_CFG : AUX_CFG;
    vfpm_rail_in_t ri;
    logic [CW-1:0] cnt;
    logic          seenAbove;
    logic          seenPwm;
    logic          trackMode;
    logic          everRan;
    logic          ovTrip;
    logic          ocTrip;
    logic          offDrop;
    assign ri = sense.rail[r];
    assign ovTrip  = trackMode ? ri.ovTrack : ri.ovFixed;
    // averaged current belongs to main rail
    assign ocTrip  = (r == 0) && (sense.avgOver | sense.imonOver);
    assign offDrop = ri.offCode && !(CFG == `VFPM_CFG_KEEP && everRan);

    // Sequencer; overvoltage wins over everything else
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        railSt[r] <= RS_OFF;
        cnt       <= '0;
      end else if (railSt[r] != RS_OVLOCK && ovTrip) begin
        railSt[r] <= RS_OVLOCK;
      end else if (railSt[r] != RS_OVLOCK && railSt[r] != RS_OFF
                   && !enabled) begin
        railSt[r] <= RS_OFF;
      end else begin
        case (railSt[r])
          RS_OFF: begin
            if (enabled) begin
              railSt[r] <= RS_DELAY;
              cnt       <= '0;
            end
          end
          RS_DELAY: begin
            if (cnt == CW'(TD1_CYC - 1)) begin
              railSt[r] <= RS_RAMP;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          RS_RAMP, RS_RUN: begin
            if (ocTrip) begin
              railSt[r] <= RS_HICCUP;
              cnt       <= '0;
            end else if (railSt[r] == RS_RAMP && ri.rampDone) begin
              railSt[r] <= RS_RUN;
            end
          end
          RS_HICCUP: begin
            if (cnt == CW'(HICCUP_CYC - 1)) begin
              railSt[r] <= RS_RAMP;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          RS_OVLOCK: begin
            if (enRise) begin
              railSt[r] <= RS_DELAY;
              cnt       <= '0;
            end
          end
          default: railSt[r] <= RS_OFF;
        endcase
      end
    end

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        seenAbove <= 1'b0;
        seenPwm   <= 1'b0;
        trackMode <= 1'b0;
      end else if (railSt[r] inside {RS_OFF, RS_DELAY, RS_HICCUP}) begin
        seenAbove <= 1'b0;
        seenPwm   <= 1'b0;
        trackMode <= 1'b0;
      end else if (railSt[r] != RS_OVLOCK) begin
        seenAbove <= seenAbove | ri.aboveRef;
        seenPwm   <= seenPwm | ri.firstPwm;
        trackMode <= trackMode
                   | (railSt[r] == RS_RUN && seenAbove && seenPwm);
      end
    end

    // low on trip, released below margin; trip wins
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        ovLow[r] <= 1'b0;
      end else if (ovTrip) begin
        ovLow[r] <= 1'b1;
      end else if (ri.ovBelow || railSt[r] != RS_OVLOCK) begin
        ovLow[r] <= 1'b0;
      end
    end

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        everRan   <= 1'b0;
        readyQ[r] <= 1'b0;
      end else begin
        everRan   <= enabled & (everRan | railSt[r] == RS_RUN);
        readyQ[r] <= (railSt[r] == RS_RUN) && !offDrop;
      end
    end

    a_ready_low: assert property (@(posedge core_clk) disable iff (reset)
      railSt[r] != RS_RUN |=> !readyQ[r])
      else $error("ready high outside run");
    a_ready_off: assert property (@(posedge core_clk) disable iff (reset)
      ri.offCode && !(CFG == `VFPM_CFG_KEEP && everRan) |=> !readyQ[r])
      else $error("ready high on off code");
    a_ovp_lock: assert property (@(posedge core_clk) disable iff (reset)
      railSt[r] == RS_OVLOCK && !enRise |=> railSt[r] == RS_OVLOCK)
      else $error("overvoltage lock left early");
    a_oc_trip: assert property (@(posedge core_clk) disable iff (reset)
      railSt[r] == RS_RUN && ocTrip && enabled && !ovTrip
      |=> railSt[r] == RS_HICCUP)
      else $error("overcurrent ignored");
    a_hiccup_wait: assert property (@(posedge core_clk) disable iff (reset)
      railSt[r] == RS_HICCUP && cnt < CW'(HICCUP_CYC - 1) && enabled
      && !ovTrip |=> railSt[r] == RS_HICCUP)
      else $error("hiccup wait cut short");
    a_delay_wait: assert property (@(posedge core_clk) disable iff (reset)
      railSt[r] == RS_DELAY && cnt < CW'(TD1_CYC - 1) && enabled
      && !ovTrip |=> railSt[r] == RS_DELAY)
      else $error("start-up delay cut short");
  end

  assign mainRailReady = '{out: 1'b0, oe: ~readyQ[0]};
  assign auxRailReady  = '{out: 1'b0, oe: ~readyQ[1]};

  ////////////////////////////////////////////////////////////////////////
  // Per-phase limiting and PWM commands
  logic [4:0] peakLim;
  for (genvar p = 0; p < 5; p++) begin : g_phase
    localparam int R = (p == `VFPM_AUX_PHASE) ? 1 : 0;
    // hold low to cycle end; new trip wins over cycle start
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        peakLim[p] <= 1'b0;
      end else if (sense.peakOver[p]) begin
        peakLim[p] <= 1'b1;
      end else if (cycleStart[p]) begin
        peakLim[p] <= 1'b0;
      end
    end

    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        pwmCmd[p] <= PWM_HIZ;
      end else begin
        case (railSt[R])
          RS_OVLOCK: pwmCmd[p] <= ovLow[R] ? PWM_LOW : PWM_HIZ;
          RS_RAMP, RS_RUN: pwmCmd[p] <= peakLim[p] ? PWM_LOW : PWM_RUN;
          default: pwmCmd[p] <= PWM_HIZ;
        endcase
      end
    end

    a_peak_low: assert property (@(posedge core_clk) disable iff (reset)
      peakLim[p] && railSt[R] == RS_RUN |=> pwmCmd[p] == PWM_LOW)
      else $error("limited phase not low");
    a_ovp_low: assert property (@(posedge core_clk) disable iff (reset)
      ovLow[R] && railSt[R] == RS_OVLOCK |=> pwmCmd[p] == PWM_LOW)
      else $error("overvoltage phase not low");
  end

  ////////////////////////////////////////////////////////////////////////
  // Thermal monitoring
  // level table
  function automatic vfpm_tlim_t tempLimits(input logic [2:0] sel);
    vfpm_tlim_t lim;
    case (sel)
      3'h0:    lim = '{`VFPM_T90_ON,  `VFPM_T90_OFF};
      3'h1:    lim = '{`VFPM_T95_ON,  `VFPM_T95_OFF};
      3'h3:    lim = '{`VFPM_T105_ON, `VFPM_T105_OFF};
      3'h4:    lim = '{`VFPM_T110_ON, `VFPM_T110_OFF};
      3'h5:    lim = '{`VFPM_T115_ON, `VFPM_T115_OFF};
      3'h6:    lim = '{`VFPM_T120_ON, `VFPM_T120_OFF};
      default: lim = '{`VFPM_T100_ON, `VFPM_T100_OFF};
    endcase
    return lim;
  endfunction : tempLimits

  vfpm_tlim_t tLim;
  logic       hotOn;
  logic       hotOff;
  logic       hot;
  assign tLim   = tempLimits(maxTempSetting);
  // Hotter means lower divider voltage
  assign hotOn  = (sense.mainThermistorSense < tLim.onLvl)
                | (sense.auxThermistorSense < tLim.onLvl);
  assign hotOff = (sense.mainThermistorSense > tLim.offLvl)
                & (sense.auxThermistorSense > tLim.offLvl);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hot <= 1'b0;
    end else if (!enabled) begin
      hot <= 1'b0;
    end else if (hotOn) begin
      hot <= 1'b1;
    end else if (hotOff) begin
      hot <= 1'b0;
    end
  end

  assign regulatorOvertempN = '{out: 1'b0, oe: hot};
  a_hot_off: assert property (@(posedge core_clk) disable iff (reset)
    !enabled |=> !hot)
    else $error("overtemp driven before enable");
  a_hot_on: assert property (@(posedge core_clk) disable iff (reset)
    enabled && hotOn |=> hot)
    else $error("overtemp not asserted");
  a_hot_hold: assert property (@(posedge core_clk) disable iff (reset)
    hot && enabled && !hotOff |=> hot)
    else $error("overtemp released early");

endmodule : vfpm_monitor
`default_nettype wire

/* vfpm_map.svh */
`ifndef VFPM_MAP_SVH
`define VFPM_MAP_SVH

// Clock period and protection timings, in ns
`define VFPM_CLK_NS       20
`define VFPM_SAMPLE_NS    132000
`define VFPM_TD1_NS       4600000
`define VFPM_HICCUP_NS    8000000
`define VFPM_SAMPLE_CYC   (`VFPM_SAMPLE_NS / `VFPM_CLK_NS)
`define VFPM_TD1_CYC      (`VFPM_TD1_NS / `VFPM_CLK_NS)
`define VFPM_HICCUP_CYC   (`VFPM_HICCUP_NS / `VFPM_CLK_NS)

// Register map and values
`define VFPM_ADDR_OUTPUT_CURRENT_READING    8'h15
`define VFPM_OUTPUT_CURRENT_READING_FULL    8'hff
`define VFPM_CFG_KEEP     8'h01
`define VFPM_CFG_MAIN_RST 8'h00
`define VFPM_CFG_AUX_RST  8'h01
`define VFPM_AUX_PHASE    4

// Overtemp assert / release levels, hundredths of a percent of supply
`define VFPM_T90_ON       14'h11c8
`define VFPM_T90_OFF      14'h1294
`define VFPM_T95_ON       14'h1082
`define VFPM_T95_OFF      14'h1144
`define VFPM_T100_ON      14'h0f48
`define VFPM_T100_OFF     14'h1002
`define VFPM_T105_ON      14'h0e1e
`define VFPM_T105_OFF     14'h0ed0
`define VFPM_T110_ON      14'h0d04
`define VFPM_T110_OFF     14'h0dac
`define VFPM_T115_ON      14'h0bfc
`define VFPM_T115_OFF     14'h0c98
`define VFPM_T120_ON      14'h0b08
`define VFPM_T120_OFF     14'h0b9a

`endif

/* vfpm_pkg.sv */
package vfpm_pkg;

  // Command to one PWM output
  typedef enum logic [1:0] {PWM_RUN, PWM_LOW, PWM_HIZ} vfpm_pwm_t;

  // Rail sequencing states
  typedef enum logic [2:0] {
    RS_OFF, RS_DELAY, RS_RAMP, RS_RUN, RS_HICCUP, RS_OVLOCK
  } vfpm_rail_st_t;

  // Per-rail comparator and sequencing inputs
  typedef struct packed {
    logic ovFixed;   // Output above fixed limit
    logic ovTrack;   // Output above reference plus tracking margin
    logic ovBelow;   // Output below reference plus release margin
    logic aboveRef;  // Output above reference
    logic firstPwm;  // First PWM pulse fired
    logic rampDone;  // Soft-start ramp finished
    logic offCode;   // Zero voltage code requested
  } vfpm_rail_in_t;

  // All asynchronous sense inputs
  typedef struct packed {
    logic [7:0]           imonCode;
    logic                 imonFull;
    logic                 imonOver;
    logic                 avgOver;
    logic [4:0]           peakOver;
    logic                 powerEnableIn;
    logic                 terminationEnableIn;
    logic [13:0]          mainThermistorSense;
    logic [13:0]          auxThermistorSense;
    vfpm_rail_in_t [1:0]  rail;
  } vfpm_sense_t;

  // Overtemp thresholds
  typedef struct packed {
    logic [13:0] onLvl;
    logic [13:0] offLvl;
  } vfpm_tlim_t;

  // Open-drain pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } vfpm_od_t;

endpackage : vfpm_pkg

/* vfpm_plant.sv */
`timescale 1ns/1ps
`default_nettype none

module vfpm_plant
  import vfpm_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset,
  // Commands from the controller
  input  wire vfpm_pwm_t [4:0] pwmCmd,
  // Rail levels seen by the comparators
  output logic [1:0]           firstPwm,
  output logic [1:0]           aboveRef
);

  logic [1:0] run;
  logic [1:0] hiz;

  // Main rail watched on phase 0, aux rail on phase 4
  assign run = {pwmCmd[4] == PWM_RUN, pwmCmd[0] == PWM_RUN};
  assign hiz = {pwmCmd[4] == PWM_HIZ, pwmCmd[0] == PWM_HIZ};

  // Output climbs past reference a cycle after the first pulse; a
  // tri-stated rail collapses, so both marks fall again
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      firstPwm <= 2'h0;
      aboveRef <= 2'h0;
    end else begin
      firstPwm <= (firstPwm | run) & ~hiz;
      aboveRef <= firstPwm & ~hiz;
    end
  end

endmodule : vfpm_plant

`default_nettype wire

/* vr_fault_protection_monitor_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end

module vr_fault_protection_monitor_tb import vfpm_pkg::*; ;

  // Bench signals
  logic            core_clk;
  logic            reset;
  vfpm_sense_t     sense;
  vfpm_sense_t     sensors;
  logic [4:0]      cycleStart;
  logic [2:0]      maxTempSetting;
  logic [7:0]      regAddr;
  logic            regRead;
  logic [7:0]      regData;
  logic            regValid;
  vfpm_pwm_t [4:0] pwmCmd;
  vfpm_od_t        mainRailReady;
  vfpm_od_t        auxRailReady;
  vfpm_od_t        regulatorOvertempN;
  vfpm_od_t        alertN;
  logic [1:0]      firstPwm;
  logic [1:0]      aboveRef;
  int              mismatches;
  int              checks;
  int              cycles;

  // Overtemp assert and release levels, 0.01% of supply, 90C upwards
  localparam logic [13:0] ON_L[7] = '{14'h11c8, 14'h1082, 14'h0f48,
    14'h0e1e, 14'h0d04, 14'h0bfc, 14'h0b08};
  localparam logic [13:0] OFF_L[7] = '{14'h1294, 14'h1144, 14'h1002,
    14'h0ed0, 14'h0dac, 14'h0c98, 14'h0b9a};

  // Short counts keep the run brief
  vfpm_monitor #(.SAMPLE_CYC(16), .TD1_CYC(20), .HICCUP_CYC(30)) i_dut (
    .core_clk(core_clk), .reset(reset), .sensors(sensors),
    .cycleStart(cycleStart), .maxTempSetting(maxTempSetting),
    .regAddr(regAddr), .regRead(regRead), .regData(regData),
    .regValid(regValid), .pwmCmd(pwmCmd), .mainRailReady(mainRailReady),
    .auxRailReady(auxRailReady), .regulatorOvertempN(regulatorOvertempN),
    .alertN(alertN));

  vfpm_plant i_plant (.core_clk(core_clk), .reset(reset), .pwmCmd(pwmCmd),
    .firstPwm(firstPwm), .aboveRef(aboveRef));

  // Plant levels replace the bench copy for those two fields
  always_comb begin
    sensors = sense;
    sensors.rail[0].firstPwm = firstPwm[0];
    sensors.rail[1].firstPwm = firstPwm[1];
    sensors.rail[0].aboveRef = aboveRef[0];
    sensors.rail[1].aboveRef = aboveRef[1];
  end

  // Clock and hang guard
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  task pe(int n);
    repeat (n) @(posedge core_clk);
  endtask : pe

  task ne(int n);
    repeat (n) @(negedge core_clk);
  endtask : ne

  // Bounded wait for one phase to reach a command
  task waitPwm(int p, vfpm_pwm_t v, int lim);
    for (int k = 0; k < lim && pwmCmd[p] !== v; k++) ne(1);
  endtask : waitPwm

  task rd(logic [7:0] a, logic [7:0] e);
    pe(1);
    regAddr <= a;
    regRead <= 1'h1;
    pe(1);
    regRead <= 1'h0;
    ne(1);
    `CHK("valid", 1'h1, regValid)
    `CHK("data", e, regData)
  endtask : rd

  task close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Idle pins, then faults while still disabled
  task t_idle();
    ne(1);
    `CHK("pwm idle", PWM_HIZ, pwmCmd[0])
    `CHK("rdy idle", 1'h1, mainRailReady.oe)
    `CHK("aux idle", 1'h1, auxRailReady.oe)
    `CHK("alert idle", 1'h0, alertN.oe)
    pe(1);
    sense.mainThermistorSense <= 14'h0100;
    sense.rail[1].ovTrack <= 1'h1;
    ne(5);
    `CHK("hot off", 1'h0, regulatorOvertempN.oe)
    `CHK("no track", PWM_HIZ, pwmCmd[4])
    pe(1);
    sense.mainThermistorSense <= 14'h2000;
    sense.rail[1].ovTrack <= 1'h0;
    sense.rail[0].ovFixed <= 1'h1;
    pe(1);
    sense.rail[0].ovFixed <= 1'h0;
    ne(5);
    `CHK("ov off", PWM_LOW, pwmCmd[0])
  endtask : t_idle

  task t_read();
    pe(1);
    sense.imonCode <= 8'h5a;
    ne(40);
    rd(8'h15, 8'h5a);
    rd(8'h16, 8'h00);
    pe(1);
    sense.imonFull <= 1'h1;
    ne(40);
    rd(8'h15, 8'hff);
    `CHK("alert", 1'h1, alertN.oe)
    pe(1);
    sense.imonFull <= 1'h0;
    ne(40);
    `CHK("alert clr", 1'h0, alertN.oe)
  endtask : t_read

  // Enable also clears the overvoltage lock left by t_idle
  task t_start();
    pe(1);
    sense.powerEnableIn <= 1'h1;
    sense.terminationEnableIn <= 1'h1;
    ne(10);
    `CHK("delay", PWM_HIZ, pwmCmd[0])
    waitPwm(0, PWM_RUN, 40);
    `CHK("ramp", PWM_RUN, pwmCmd[0])
    `CHK("aux ramp", PWM_RUN, pwmCmd[4])
    `CHK("rdy ramp", 1'h1, mainRailReady.oe)
    pe(1);
    sense.rail[0].rampDone <= 1'h1;
    sense.rail[1].rampDone <= 1'h1;
    ne(6);
    `CHK("rdy", 1'h0, mainRailReady.oe)
    `CHK("aux rdy", 1'h0, auxRailReady.oe)
  endtask : t_start

  task t_offcode();
    pe(1);
    sense.rail[0].offCode <= 1'h1;
    sense.rail[1].offCode <= 1'h1;
    ne(5);
    `CHK("off main", 1'h1, mainRailReady.oe)
    `CHK("off aux", 1'h0, auxRailReady.oe)
    pe(1);
    sense.rail[0].offCode <= 1'h0;
    sense.rail[1].offCode <= 1'h0;
    ne(5);
    `CHK("on main", 1'h0, mainRailReady.oe)
  endtask : t_offcode

  task t_peak();
    pe(1);
    sense.peakOver <= 5'h02;
    ne(5);
    `CHK("limit", PWM_LOW, pwmCmd[1])
    `CHK("other", PWM_RUN, pwmCmd[0])
    pe(1);
    sense.peakOver <= 5'h00;
    ne(4);
    `CHK("rest", PWM_LOW, pwmCmd[1])
    pe(1);
    cycleStart <= 5'h02;
    pe(1);
    cycleStart <= 5'h00;
    ne(3);
    `CHK("next", PWM_RUN, pwmCmd[1])
    `CHK("no stop", 1'h0, mainRailReady.oe)
  endtask : t_peak

  // Average then monitor-pin overcurrent, each with a full retry
  task t_ocp();
    for (int k = 0; k < 2; k++) begin
      pe(1);
      if (k == 0) sense.avgOver <= 1'h1;
      else sense.imonOver <= 1'h1;
      pe(1);
      sense.avgOver <= 1'h0;
      sense.imonOver <= 1'h0;
      ne(6);
      `CHK("oc hiz", PWM_HIZ, pwmCmd[0])
      `CHK("oc rdy", 1'h1, mainRailReady.oe)
      `CHK("oc aux", PWM_RUN, pwmCmd[4])
      ne(15);
      `CHK("oc wait", PWM_HIZ, pwmCmd[0])
      waitPwm(0, PWM_RUN, 40);
      `CHK("retry", PWM_RUN, pwmCmd[0])
      ne(6);
      `CHK("oc back", 1'h0, mainRailReady.oe)
    end
  endtask : t_ocp

  task t_thermal();
    for (int i = 0; i < 7; i++) begin
      pe(1);
      maxTempSetting <= 3'(i);
      sense.mainThermistorSense <= ON_L[i] - 14'h0001;
      ne(5);
      `CHK("hot", 1'h1, regulatorOvertempN.oe)
      pe(1);
      sense.mainThermistorSense <= OFF_L[i];
      ne(5);
      `CHK("hot hold", 1'h1, regulatorOvertempN.oe)
      pe(1);
      sense.mainThermistorSense <= OFF_L[i] + 14'h0001;
      ne(5);
      `CHK("cool", 1'h0, regulatorOvertempN.oe)
    end
  endtask : t_thermal

  // Trip, release, recur, stay latched, then enable cycling
  task t_ovp();
    for (int k = 0; k < 2; k++) begin
      // Past 2.3V is also past the tracking limit once tracking
      pe(1);
      sense.rail[0].ovFixed <= 1'h1;
      sense.rail[0].ovTrack <= 1'h1;
      pe(1);
      sense.rail[0].ovFixed <= 1'h0;
      sense.rail[0].ovTrack <= 1'h0;
      ne(5);
      `CHK("ov low", PWM_LOW, pwmCmd[0])
      `CHK("ov low3", PWM_LOW, pwmCmd[3])
      `CHK("ov rdy", 1'h1, mainRailReady.oe)
      pe(1);
      sense.rail[0].ovBelow <= 1'h1;
      pe(2);
      sense.rail[0].ovBelow <= 1'h0;
      ne(4);
      `CHK("ov hiz", PWM_HIZ, pwmCmd[0])
    end
    ne(40);
    `CHK("ov latch", PWM_HIZ, pwmCmd[0])
    `CHK("ov rdy hold", 1'h1, mainRailReady.oe)
    pe(1);
    sense.powerEnableIn <= 1'h0;
    pe(4);
    sense.powerEnableIn <= 1'h1;
    waitPwm(0, PWM_RUN, 60);
    `CHK("ov restart", PWM_RUN, pwmCmd[0])
    ne(6);
    `CHK("ov rdy back", 1'h0, mainRailReady.oe)
  endtask : t_ovp

  task t_track();
    pe(1);
    sense.rail[1].ovTrack <= 1'h1;
    pe(1);
    sense.rail[1].ovTrack <= 1'h0;
    ne(5);
    `CHK("track", PWM_LOW, pwmCmd[4])
    `CHK("track rdy", 1'h1, auxRailReady.oe)
    `CHK("main free", PWM_RUN, pwmCmd[0])
  endtask : t_track

  // Main sequence
  initial begin
    core_clk = 1'h0;
    reset = 1'h1;
    sense = '0;
    sense.mainThermistorSense = 14'h2000;
    sense.auxThermistorSense = 14'h2000;
    cycleStart = 5'h00;
    maxTempSetting = 3'h2;
    regAddr = 8'h00;
    regRead = 1'h0;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    pe(2);
    reset <= 1'h0;
    t_idle();
    t_read();
    t_start();
    t_offcode();
    t_peak();
    t_ocp();
    t_thermal();
    t_ovp();
    t_track();
    close_out();
  end

endmodule : vr_fault_protection_monitor_tb

`default_nettype wire
